// ---- tb_top.sv ----
// Self-checking bench for the line and modem control block.
// Assumes ulm_consts.svh and ulm_pkg; drives a classic Wishbone master.
`timescale 1ns/10ps
`include "ulm_consts.svh"

module tb_top;
    logic clk_i;
    logic rst_i;
    logic cyc;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    logic tx;
    logic [4:0] lvl;
    logic sin;
    logic sout;
    logic rxs;
    logic dsel;
    ulm_pkg::ulm_format_t fmt;
    ulm_pkg::ulm_modem_in_t min;
    ulm_pkg::ulm_modem_out_t mout;
    ulm_pkg::ulm_modem_status_t mst;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [7:0] v;
    logic [7:0] m;
    logic brk;
    logic [3:0] st;
    int error_cnt;
    int check_count;
    int cyc_cnt = 0;

    ulm_line_modem_ctrl u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .tx_serial_i(tx), .sin_i(sin),
        .sout_o(sout), .rx_serial_o(rxs), .divisor_access_select_o(dsel),
        .format_o(fmt), .modem_in_i(min), .modem_out_o(mout),
        .modem_status_o(mst)
    );

    ulm_peer_model u_peer (
        .clk_i(clk_i), .level_i(lvl), .modem_in_o(min), .sin_o(sin)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic ulm_pkg::ulm_format_t exp_fmt(input logic [7:0] x);
        ulm_pkg::ulm_format_t f;
        f.char_bits = 4'h5 + {2'h0, x[1:0]};
        f.stop_halves = x[2] ? ((x[1:0] == 2'h0) ? 3'h3 : 3'h4) : 3'h2;
        f.parity_en = x[3];
        f.parity_even = x[4];
        return f;
    endfunction

    task automatic summarize();
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_bus(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_pin(input string n, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    // Hold the request until ack, take data at that edge, then idle
    task automatic wb(input logic w, input logic [31:0] a, d,
                      input logic [3:0] s);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        // Only the bench timeout ends a wait that never sees ack
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        sel = 4'h0;
        wdat = 32'h0;
        tx = 1'b1;
        lvl = 5'h1F;
        seed = 32'hA8B4;
        error_cnt = 0;
        check_count = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk_pin("mout_rst", 16'h000F, {12'h0, mout});
        wb(1'b0, `ULM_FMT_ADDR, 32'h0, 4'hF);
        chk_bus("fmt_rst", 32'h0, rd);
        wb(1'b0, `ULM_HSK_ADDR, 32'h0, 4'hF);
        chk_bus("hsk_rst", 32'h0, rd);
        // Every length and stop pairing, random upper bits
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            v = {seed[7:3], i[2:0]};
            tx <= seed[8];
            wb(1'b1, `ULM_FMT_ADDR, {seed[31:8], v}, 4'hF);
            wb(1'b0, `ULM_FMT_ADDR, 32'h0, 4'hF);
            chk_bus("fmt_byte", {24'h0, v}, rd);
            chk_pin("fmt", {7'h0, exp_fmt(v)}, {7'h0, fmt});
            chk_pin("dsel", {15'h0, v[7]}, {15'h0, dsel});
            chk_pin("sout", {15'h0, ~v[6] & tx}, {15'h0, sout});
        end
        // Loopback on and off, with and without break
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            brk = i[1];
            m = {seed[7:5], i[0], seed[3:0]};
            lvl <= seed[20:16];
            tx <= seed[10];
            wb(1'b1, `ULM_FMT_ADDR, {24'h0, 1'b0, brk, 6'h03}, 4'hF);
            wb(1'b1, `ULM_HSK_ADDR, {24'h0, m}, 4'h1);
            wb(1'b0, `ULM_HSK_ADDR, 32'h0, 4'hF);
            chk_bus("hsk", {24'h0, m}, rd);
            st = m[4] ? {m[3], m[2], m[0], m[1]} : ~lvl[3:0];
            chk_pin("mout", {12'h0, ~m[3:0]}, {12'h0, mout});
            chk_pin("mst", {12'h0, st}, {12'h0, mst});
            chk_pin("rx", {15'h0, m[4] ? tx & ~brk : lvl[4]},
                {15'h0, rxs});
            chk_pin("sout_l", {15'h0, m[4] | (~brk & tx)},
                {15'h0, sout});
            wb(1'b0, `ULM_VIEW_ADDR, 32'h0, 4'hF);
            chk_bus("view", {24'h0, st, 4'h0}, rd);
        end
        // Refused writes leave state alone, then a full-word write keeps only the low byte
        wb(1'b1, `ULM_HSK_ADDR, 32'h0000_00FF, 4'hE);
        wb(1'b0, `ULM_HSK_ADDR, 32'h0, 4'hF);
        chk_bus("sel0", {24'h0, m}, rd);
        wb(1'b1, 32'hBD000020, 32'h0000_00FF, 4'hF);
        wb(1'b0, 32'hBD000020, 32'h0, 4'hF);
        chk_bus("unmap", 32'h0, rd);
        wb(1'b1, `ULM_HSK_ADDR, 32'hFFFF_FFFF, 4'hF);
        wb(1'b0, `ULM_HSK_ADDR, 32'h0, 4'hF);
        chk_bus("hsk_hi", 32'h0000_00FF, rd);
        summarize();
    end
endmodule

// ---- ulm_consts.svh ----
// Offsets, field positions, reset values and encodings for the line and
// modem control block. Included by bare name; definitions only.
`ifndef ULM_CONSTS_SVH
`define ULM_CONSTS_SVH

`define ULM_FMT_ADDR 32'hBD00000C
`define ULM_HSK_ADDR 32'hBD000010
`define ULM_VIEW_ADDR 32'hBD00001C

`define ULM_FMT_DIV_SEL 7
`define ULM_FMT_BRK 6
`define ULM_FMT_STICK 5
`define ULM_FMT_PAR_EVEN 4
`define ULM_FMT_PAR_EN 3
`define ULM_FMT_STOP 2
`define ULM_FMT_LEN_HI 1
`define ULM_FMT_LEN_LO 0

`define ULM_HSK_LOOP 4
`define ULM_HSK_USER_B 3
`define ULM_HSK_USER_A 2
`define ULM_HSK_RTS 1
`define ULM_HSK_DTR 0

`define ULM_VIEW_DCD 7
`define ULM_VIEW_RI 6
`define ULM_VIEW_DSR 5
`define ULM_VIEW_CTS 4

`define ULM_FMT_RST 8'h00
`define ULM_HSK_RST 8'h00

`define ULM_CHAR_MIN 4'h5
`define ULM_STOP_ONE 3'h2
`define ULM_STOP_ONE_HALF 3'h3
`define ULM_STOP_TWO 3'h4

`endif

// ---- ulm_format_decode.sv ----
// Decodes the line format byte into character length and stop length.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "ulm_consts.svh"

module ulm_format_decode (
    input wire logic [7:0] line_format_i,
    output ulm_pkg::ulm_format_t format_o
);

    logic [1:0] char_len_field;

    always_comb begin
        char_len_field = line_format_i[`ULM_FMT_LEN_HI:`ULM_FMT_LEN_LO];
        format_o.char_bits = `ULM_CHAR_MIN + {2'h0, char_len_field};
        format_o.parity_en = line_format_i[`ULM_FMT_PAR_EN];
        format_o.parity_even = line_format_i[`ULM_FMT_PAR_EVEN];
        if (!line_format_i[`ULM_FMT_STOP]) begin
            format_o.stop_halves = `ULM_STOP_ONE;
        end else if (char_len_field == 2'h0) begin
            format_o.stop_halves = `ULM_STOP_ONE_HALF;
        end else begin
            format_o.stop_halves = `ULM_STOP_TWO;
        end
    end

endmodule

// ---- ulm_line_modem_ctrl.sv ----
// Line format and modem control registers with loopback steering.
// Assumes a classic Wishbone master, a transmit engine that reads
// format_o, and a receiver that takes rx_serial_o.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`include "ulm_consts.svh"

// Summary of operation
// - Divisor access bit steers latch byte access
// - Break bit holds serial output low outside loopback
// - Break in loopback reaches own receiver
// - Parity sense: zero odd, one even
// - Parity bit sent only when enabled
// - Stop length one or two bits
// - Five-bit characters get 1.5 stops when the stop bit is set
// - Length field gives five to eight bits
// - Loopback holds output high, feeds receiver
// - Interrupt sources stay live in loopback
// - Loopback replaces modem inputs with outputs
// - User output b pin is inverse bit
// - User output a pin is inverse bit
// - Request-to-send pin is inverse bit
// - Terminal-ready pin is inverse bit
// - Loopback maps carrier, ring, set-ready status
module ulm_line_modem_ctrl #(
    parameter int ADDR_W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tx_serial_i,
    input wire logic sin_i,
    output logic sout_o,
    output logic rx_serial_o,
    output logic divisor_access_select_o,
    output ulm_pkg::ulm_format_t format_o,
    input wire ulm_pkg::ulm_modem_in_t modem_in_i,
    output ulm_pkg::ulm_modem_out_t modem_out_o,
    output ulm_pkg::ulm_modem_status_t modem_status_o
);

    generate
        if (ADDR_W < 32) begin : g_bad_addr
            $error("ADDR_W must be at least 32");
        end
    endgenerate

    ulm_pkg::ulm_state_t s_r;
    ulm_pkg::ulm_state_t s_nxt;
    ulm_pkg::ulm_format_t fmt_dec;

    logic req;
    logic commit_wr;
    logic hit_fmt;
    logic hit_hsk;
    logic [7:0] fmt_byte_nxt;
    logic hit_view;
    logic loop_nxt;
    logic brk_nxt;
    logic [3:0] ctl_bits;

    // Only the low 32 address bits are compared, so with ADDR_W above 32 the block aliases across the upper bits
    assign hit_fmt = (32'(wb_adr_i) == `ULM_FMT_ADDR);
    assign hit_hsk = (32'(wb_adr_i) == `ULM_HSK_ADDR);
    assign hit_view = (32'(wb_adr_i) == `ULM_VIEW_ADDR);
    assign req = wb_cyc_i && wb_stb_i;
    // Write lands on the edge where the master sees ack
    assign commit_wr = req && s_r.ack && wb_we_i && wb_sel_i[0];

    // Decoder fed apart from s_nxt to keep the state struct loop-free
    assign fmt_byte_nxt = (commit_wr && hit_fmt) ? wb_dat_i[7:0]
        : s_r.serial_line_format;

    ulm_format_decode u_decode (
        .line_format_i(fmt_byte_nxt),
        .format_o(fmt_dec)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = req && !s_r.ack;
        s_nxt.serial_line_format = fmt_byte_nxt;
        if (commit_wr && hit_hsk) begin
            s_nxt.handshake_output_control = wb_dat_i[7:0];
        end
        // Unmapped addresses still ack, reading zero
        s_nxt.rdat = 32'h00000000;
        if (req && !s_r.ack && !wb_we_i) begin
            if (hit_fmt) begin
                s_nxt.rdat[7:0] = s_r.serial_line_format;
            end else if (hit_hsk) begin
                s_nxt.rdat[7:0] = s_r.handshake_output_control;
            end else if (hit_view) begin
                s_nxt.rdat[`ULM_VIEW_DCD] = s_r.mstat.dcd;
                s_nxt.rdat[`ULM_VIEW_RI] = s_r.mstat.ri;
                s_nxt.rdat[`ULM_VIEW_DSR] = s_r.mstat.dsr;
                s_nxt.rdat[`ULM_VIEW_CTS] = s_r.mstat.cts;
            end
        end

        // Everything below follows the new register values in the same edge
        s_nxt.div_sel = s_nxt.serial_line_format[`ULM_FMT_DIV_SEL];
        s_nxt.fmt = fmt_dec;
        loop_nxt = s_nxt.handshake_output_control[`ULM_HSK_LOOP];
        brk_nxt = s_nxt.serial_line_format[`ULM_FMT_BRK];

        if (loop_nxt) begin
            s_nxt.sout = 1'b1;
            s_nxt.rx_ser = tx_serial_i && !brk_nxt;
        end else begin
            s_nxt.sout = tx_serial_i && !brk_nxt;
            s_nxt.rx_ser = sin_i;
        end

        ctl_bits = s_nxt.handshake_output_control[3:0];
        // Pins keep following the bits in loopback as well
        s_nxt.mout.user_output_b_pin_n = !ctl_bits[`ULM_HSK_USER_B];
        s_nxt.mout.user_output_a_pin_n = !ctl_bits[`ULM_HSK_USER_A];
        s_nxt.mout.rts_n = !ctl_bits[`ULM_HSK_RTS];
        s_nxt.mout.dtr_n = !ctl_bits[`ULM_HSK_DTR];

        // Status path is not gated in loopback so change detection
        // and its interrupt downstream keep working
        if (loop_nxt) begin
            s_nxt.mstat.dcd = ctl_bits[`ULM_HSK_USER_B];
            s_nxt.mstat.ri = ctl_bits[`ULM_HSK_USER_A];
            s_nxt.mstat.dsr = ctl_bits[`ULM_HSK_DTR];
            s_nxt.mstat.cts = ctl_bits[`ULM_HSK_RTS];
        end else begin
            s_nxt.mstat.dcd = !modem_in_i.dcd_n;
            s_nxt.mstat.ri = !modem_in_i.ri_n;
            s_nxt.mstat.dsr = !modem_in_i.dsr_n;
            s_nxt.mstat.cts = !modem_in_i.cts_n;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r.serial_line_format <= `ULM_FMT_RST;
            s_r.handshake_output_control <= `ULM_HSK_RST;
            s_r.ack <= 1'b0;
            s_r.rdat <= 32'h00000000;
            s_r.fmt.char_bits <= `ULM_CHAR_MIN;
            s_r.fmt.stop_halves <= `ULM_STOP_ONE;
            s_r.fmt.parity_en <= 1'b0;
            s_r.fmt.parity_even <= 1'b0;
            s_r.div_sel <= 1'b0;
            s_r.sout <= 1'b1;
            s_r.rx_ser <= 1'b1;
            s_r.mout <= 4'hF;
            s_r.mstat <= 4'h0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.rdat;
    assign sout_o = s_r.sout;
    assign rx_serial_o = s_r.rx_ser;
    assign divisor_access_select_o = s_r.div_sel;
    assign format_o = s_r.fmt;
    assign modem_out_o = s_r.mout;
    assign modem_status_o = s_r.mstat;

    logic loop_r;
    logic brk_r;
    assign loop_r = s_r.handshake_output_control[`ULM_HSK_LOOP];
    assign brk_r = s_r.serial_line_format[`ULM_FMT_BRK];

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i)
        (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack not a single cycle after request");

    property p_div_sel;
        @(posedge clk_i) disable iff (rst_i)
        (commit_wr && hit_fmt) |=>
            divisor_access_select_o == $past(wb_dat_i[7]);
    endproperty
    a_div_sel: assert property (p_div_sel)
        else $error("divisor select does not follow written bit");

    property p_break_low;
        @(posedge clk_i) disable iff (rst_i)
        (brk_r && !loop_r) |-> !sout_o;
    endproperty
    a_break_low: assert property (p_break_low)
        else $error("serial output not low during break");

    property p_break_loop;
        @(posedge clk_i) disable iff (rst_i)
        (brk_r && loop_r) |-> (!rx_serial_o && sout_o);
    endproperty
    a_break_loop: assert property (p_break_loop)
        else $error("break not looped to receiver");

    property p_parity;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (format_o.parity_even == s_r.serial_line_format[4])
            && (format_o.parity_en == s_r.serial_line_format[3]);
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity controls do not match format byte");

    property p_stop_len;
        @(posedge clk_i) disable iff (rst_i)
        (s_r.serial_line_format[2] == 1'b0) |->
            format_o.stop_halves == 3'h2;
    endproperty
    a_stop_len: assert property (p_stop_len)
        else $error("one stop bit not selected");

    property p_stop_half;
        @(posedge clk_i) disable iff (rst_i)
        (s_r.serial_line_format[2] &&
            s_r.serial_line_format[1:0] == 2'h0) |->
            format_o.stop_halves == 3'h3;
    endproperty
    a_stop_half: assert property (p_stop_half)
        else $error("five-bit character lacks 1.5 stop bits");

    property p_char_len;
        @(posedge clk_i) disable iff (rst_i)
        (s_r.serial_line_format[1:0] == 2'h3) |->
            format_o.char_bits == 4'h8;
    endproperty
    a_char_len: assert property (p_char_len)
        else $error("length field 11 does not give eight bits");

    property p_loop_out;
        @(posedge clk_i) disable iff (rst_i)
        (loop_r && !brk_r) |-> sout_o &&
            rx_serial_o == $past(tx_serial_i);
    endproperty
    a_loop_out: assert property (p_loop_out)
        else $error("loopback serial path wrong");

    property p_pins;
        @(posedge clk_i) disable iff (rst_i)
        modem_out_o == ~s_r.handshake_output_control[3:0];
    endproperty
    a_pins: assert property (p_pins)
        else $error("modem output pins not inverse of control bits");

    property p_loop_status;
        @(posedge clk_i) disable iff (rst_i)
        loop_r |-> modem_status_o == {
            s_r.handshake_output_control[3],
            s_r.handshake_output_control[2],
            s_r.handshake_output_control[0],
            s_r.handshake_output_control[1]};
    endproperty
    a_loop_status: assert property (p_loop_status)
        else $error("loopback modem status mapping wrong");

    property p_ext_status;
        @(posedge clk_i) disable iff (rst_i)
        !loop_r |-> modem_status_o == ~$past(modem_in_i);
    endproperty
    a_ext_status: assert property (p_ext_status)
        else $error("modem status does not follow pins");

    property p_rdat_idle;
        @(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h00000000;
    endproperty
    a_rdat_idle: assert property (p_rdat_idle)
        else $error("read data not zero outside ack");

    property p_char_short;
        @(posedge clk_i) disable iff (rst_i)
        (s_r.serial_line_format[1:0] == 2'h0) |->
            format_o.char_bits == `ULM_CHAR_MIN;
    endproperty
    a_char_short: assert property (p_char_short)
        else $error("length field 00 does not give five bits");

    property p_stop_two;
        @(posedge clk_i) disable iff (rst_i)
        (s_r.serial_line_format[2] &&
            s_r.serial_line_format[1:0] != 2'h0) |->
            format_o.stop_halves == `ULM_STOP_TWO;
    endproperty
    a_stop_two: assert property (p_stop_two)
        else $error("two stop bits not selected");

    c_write_fmt: cover property (@(posedge clk_i) disable iff (rst_i)
        commit_wr && hit_fmt);
    c_loopback: cover property (@(posedge clk_i) disable iff (rst_i)
        loop_r && brk_r);
    c_read_view: cover property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && hit_view && wb_ack_o);
    c_break_line: cover property (@(posedge clk_i) disable iff (rst_i)
        brk_r && !loop_r && !sout_o);
    c_five_bit: cover property (@(posedge clk_i) disable iff (rst_i)
        format_o.stop_halves == `ULM_STOP_ONE_HALF);

endmodule

// ---- ulm_peer_model.sv ----
// Serial peer and modem model facing the line and handshake pins.
// Assumes the bench picks the levels that the peer puts on its lines.
`timescale 1ns/10ps

module ulm_peer_model (
    input wire logic clk_i,
    input wire logic [4:0] level_i,
    output ulm_pkg::ulm_modem_in_t modem_in_o,
    output logic sin_o
);
    // Lines move just after an edge, like real equipment
    always_ff @(posedge clk_i) begin
        modem_in_o <= level_i[3:0];
        sin_o <= level_i[4];
    end
endmodule

// ---- ulm_pkg.sv ----
// Types shared by the line and modem control block and its decoder.
// Assumes ulm_consts.svh for the numeric constants.
package ulm_pkg;

    // Transmit format as the shift engine wants it
    typedef struct packed {
        logic [3:0] char_bits;
        logic [2:0] stop_halves;
        logic parity_en;
        logic parity_even;
    } ulm_format_t;

    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ulm_modem_in_t;

    typedef struct packed {
        logic user_output_b_pin_n;
        logic user_output_a_pin_n;
        logic rts_n;
        logic dtr_n;
    } ulm_modem_out_t;

    // True-sense modem status, loopback already applied
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } ulm_modem_status_t;

    typedef struct packed {
        logic [7:0] serial_line_format;
        logic [7:0] handshake_output_control;
        logic ack;
        logic [31:0] rdat;
        ulm_format_t fmt;
        logic div_sel;
        logic sout;
        logic rx_ser;
        ulm_modem_out_t mout;
        ulm_modem_status_t mstat;
    } ulm_state_t;

endpackage
